//--- pkg/rts_pkg.sv
// Constants and types shared by the ramp time selector design.
// How it works
// - Ramp times span zero to maximum frequency.
// - Time unit selector resets to coarse.
// - Unit 0: steps of 0.01 s, to 600.00.
// - Unit 1: steps of 0.1 s, to 6000.0.
// - Four ramp sets, terminal codes 7 and 1A.
// - Set changes apply at once while running.
// - Terminal pair binary-decodes to sets 1..4.
// - Switch frequency changes the set automatically.
// - Below switch use set 4, else 1.
// - Configured select terminals override automatic switching.
// - Switch frequency zero disables automatic switching.
// - Analog function code 5 enables time gain.
// - Effective time is programmed time times gain.
// - Four separate S-curve durations are applied.
// - Acceleration grows by half its S-curve sum.
// - Deceleration grows by half its S-curve sum.
package rts_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses of aligned 32-bit words.
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TIME0 = 8'h00; // Sets 1..4, accel then decel.
  localparam logic [7:0] ADDR_UNIT = 8'h20;
  localparam logic [7:0] ADDR_MFI = 8'h24;
  localparam logic [7:0] ADDR_AIN = 8'h28;
  localparam logic [7:0] ADDR_SWF = 8'h2c;
  localparam logic [7:0] ADDR_SCRV0 = 8'h30; // Four S-curve words.
  localparam logic [7:0] ADDR_TARGET = 8'h40;
  localparam logic [7:0] ADDR_FMAX = 8'h44;
  localparam logic [7:0] ADDR_STAT = 8'h48;
  localparam logic [7:0] ADDR_EFF_ACC = 8'h4c;
  localparam logic [7:0] ADDR_EFF_DEC = 8'h50;

  // ----------------------------------------------------------------
  // Reset values and codes.
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_TIME = 16'h0064; // 10.0 s in 0.1 s steps.
  localparam logic RST_UNIT = 1'b1;
  localparam logic [7:0] RST_SCRV_A = 8'h14; // 0.20 s.
  localparam logic [7:0] RST_SCRV_Z = 8'h00; // 0.00 s.
  localparam logic [13:0] RST_FMAX = 14'h1770; // Plain default, 60.00 Hz.
  localparam logic [7:0] FUNC_SEL1 = 8'h07;
  localparam logic [7:0] FUNC_SEL2 = 8'h1a;
  localparam logic [7:0] FUNC_GAIN = 8'h05;
  localparam logic [1:0] SET1 = 2'h0;
  localparam logic [1:0] SET4 = 2'h3;

  // ----------------------------------------------------------------
  // Scaling and timing.
  // ----------------------------------------------------------------
  localparam logic [19:0] COARSE_MUL = 20'h0000a; // 0.1 s per 0.01 s tick.
  localparam logic [13:0] SWF_MUL = 14'h000a; // 0.1 Hz to 0.01 Hz.
  localparam int GAIN_FRAC = 9; // Analog code 512 is a gain of one.
  localparam int TICK_NS = 10000000; // Ramp tick, 0.01 s.
  localparam int CLK_NS = 50;
  localparam int MIN_TICK = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BEGIN = 2'b01,
    ST_LINEAR = 2'b10,
    ST_END = 2'b11
  } rts_state_e;

  typedef struct packed {
    rts_state_e state;
    logic dir;
    logic [1:0] set;
    logic [13:0] freq;
  } rts_stat_s;

endpackage

//--- logic/rts_ramp_core.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
// Ramp time selection, gain, S-curve shaping and APB register file.
module rts_ramp_core
  import rts_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_NS / CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] term_in,
  input wire logic [9:0] analog_input_second,
  output logic [13:0] freq_cmd,
  output logic [1:0] ramp_set,
  output logic ramping
);

  if (TICK_CYC < MIN_TICK) begin : g_chk
    $error("TICK_CYC too small for one step per cycle draining.");
  end

  localparam int TW = $clog2(TICK_CYC + 1);

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  // Flags which of the two function slots holds a code.
  function automatic logic [1:0] has_code(input logic [15:0] pair,
                                          input logic [7:0] code);
    return {pair[15:8] == code, pair[7:0] == code};
  endfunction

  // Setting to 0.01 s ticks according to the unit selector.
  function automatic logic [19:0] to_ticks(input logic [15:0] v,
                                           input logic unit);
    logic [19:0] w;
    w = {4'h0, v};
    return unit ? 20'(w * COARSE_MUL) : w;
  endfunction

  // Programmed ticks times analog gain.
  function automatic logic [20:0] scale(input logic [19:0] t,
                                        input logic [9:0] g,
                                        input logic on);
    logic [29:0] p;
    p = 30'(t) * 30'(g);
    return on ? p[29:9] : {1'b0, t};
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  logic [1:0] term_m;
  logic [1:0] term_s;
  logic [9:0] ain_m;
  logic [9:0] ain_s;

  // The analog code is assumed slow; a rare mixed sample only jitters gain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_m <= '0;
      term_s <= '0;
      ain_m <= '0;
      ain_s <= '0;
    end else begin
      term_m <= term_in;
      term_s <= term_m;
      ain_m <= analog_input_second;
      ain_s <= ain_m;
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  logic [15:0] ramp_time [8];
  logic [7:0] scurve [4];
  logic unit_sel;
  logic [15:0] mfi_func;
  logic [15:0] ain_func;
  logic [11:0] swf;
  logic [13:0] target;
  logic [13:0] fmax;
  rts_stat_s stat;

  // APB decode; the slave never waits, so pready is tied high.
  wire acc_ph = psel & penable;
  wire hit_time = paddr[7:5] == ADDR_TIME0[7:5];
  wire hit_scrv = paddr[7:4] == ADDR_SCRV0[7:4];
  wire [20:0] eff_acc;
  wire [20:0] eff_dec;
  wire mapped = (paddr[1:0] == 2'h0) & (hit_time | hit_scrv |
                paddr == ADDR_UNIT | paddr == ADDR_MFI |
                paddr == ADDR_AIN | paddr == ADDR_SWF |
                paddr == ADDR_TARGET | paddr == ADDR_FMAX |
                paddr == ADDR_STAT | paddr == ADDR_EFF_ACC |
                paddr == ADDR_EFF_DEC);
  wire wr_en = acc_ph & pwrite & mapped;
  wire [31:0] rd_val =
    !mapped ? 32'h0000_0000 :
    hit_time ? {16'h0000, ramp_time[paddr[4:2]]} :
    hit_scrv ? {24'h00_0000, scurve[paddr[3:2]]} :
    paddr == ADDR_UNIT ? {31'h0, unit_sel} :
    paddr == ADDR_MFI ? {16'h0000, mfi_func} :
    paddr == ADDR_AIN ? {16'h0000, ain_func} :
    paddr == ADDR_SWF ? {20'h0_0000, swf} :
    paddr == ADDR_TARGET ? {18'h0_0000, target} :
    paddr == ADDR_FMAX ? {18'h0_0000, fmax} :
    paddr == ADDR_STAT ? {13'h0000, stat} :
    paddr == ADDR_EFF_ACC ? {11'h000, eff_acc} : {11'h000, eff_dec};

  assign pready = 1'b1;
  assign pslverr = acc_ph & ~mapped;

  // Read data is caught in the setup cycle so it leaves a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel & ~penable) begin
      prdata <= rd_val;
    end
  end

  // Software writes; all settings may change while the motor runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) ramp_time[i] <= RST_TIME;
      scurve[0] <= RST_SCRV_A;
      scurve[1] <= RST_SCRV_A;
      scurve[2] <= RST_SCRV_A;
      scurve[3] <= RST_SCRV_Z;
      unit_sel <= RST_UNIT;
      mfi_func <= '0;
      ain_func <= '0;
      swf <= '0;
      target <= '0;
      fmax <= RST_FMAX;
    end else if (wr_en) begin
      if (hit_time) ramp_time[paddr[4:2]] <= pwdata[15:0];
      if (hit_scrv) scurve[paddr[3:2]] <= pwdata[7:0];
      if (paddr == ADDR_UNIT) unit_sel <= pwdata[0];
      if (paddr == ADDR_MFI) mfi_func <= pwdata[15:0];
      if (paddr == ADDR_AIN) ain_func <= pwdata[15:0];
      if (paddr == ADDR_SWF) swf <= pwdata[11:0];
      if (paddr == ADDR_TARGET) target <= pwdata[13:0];
      if (paddr == ADDR_FMAX) fmax <= pwdata[13:0];
    end
  end

  // ----------------------------------------------------------------
  // Ramp set selection.
  // ----------------------------------------------------------------
  wire [1:0] slot1 = has_code(mfi_func, FUNC_SEL1);
  wire [1:0] slot2 = has_code(mfi_func, FUNC_SEL2);
  wire cfg = |{slot1, slot2};
  wire sel1 = |(slot1 & term_s);
  wire sel2 = |(slot2 & term_s);
  wire auto_en = swf != 12'h000;
  wire [13:0] swf_hz = 14'(14'(swf) * SWF_MUL);
  wire above = freq_cmd >= swf_hz;
  wire [1:0] next_set = cfg ? {sel2, sel1} :
                        !auto_en ? SET1 :
                        above ? SET1 : SET4;

  // Registered set; new times take effect from the next cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_set <= SET1;
    end else begin
      ramp_set <= next_set;
    end
  end

  // ----------------------------------------------------------------
  // Effective times in 0.01 s ticks.
  // ----------------------------------------------------------------
  wire gain_on = |has_code(ain_func, FUNC_GAIN);
  wire [15:0] sel_acc = ramp_time[{ramp_set, 1'b0}];
  wire [15:0] sel_dec = ramp_time[{ramp_set, 1'b1}];
  wire [20:0] t_acc = scale(to_ticks(sel_acc, unit_sel), ain_s,
                            gain_on);
  wire [20:0] t_dec = scale(to_ticks(sel_dec, unit_sel), ain_s,
                            gain_on);
  assign eff_acc = t_acc + 21'((9'(scurve[0]) + 9'(scurve[1])) >> 1);
  assign eff_dec = t_dec + 21'((9'(scurve[2]) + 9'(scurve[3])) >> 1);

  // ----------------------------------------------------------------
  // Ramp generator.
  // ----------------------------------------------------------------
  rts_state_e state;
  rts_state_e next_state;
  logic dir;
  logic [7:0] w;
  logic [29:0] acc;
  logic [TW-1:0] tick_cnt;

  wire tick = tick_cnt == TW'(TICK_CYC - 1);
  wire want_up = target > freq_cmd;
  wire want_dn = target < freq_cmd;
  wire dir_now = (state == ST_IDLE) ? want_up : dir;
  wire [20:0] t_act = dir_now ? t_acc : t_dec;
  // Durations follow the direction about to be used, so an idle ramp
  // already knows whether its start segment is empty and can skip it.
  wire [7:0] s_beg = dir_now ? scurve[0] : scurve[2];
  wire [7:0] s_end = dir_now ? scurve[1] : scurve[3];
  wire [13:0] rem = dir ? 14'(target - freq_cmd) : 14'(freq_cmd - target);
  wire [35:0] near_lhs = 36'({rem, 1'b0}) * 36'(t_act);
  wire [35:0] near_rhs = 36'(fmax) * 36'(s_end);
  wire near = (s_end != 8'h00) & (near_lhs <= near_rhs);
  wire reversed = dir ? want_dn : want_up;
  // Within an S segment the rate weight is w/S; elsewhere it is one.
  wire [7:0] num = (state == ST_BEGIN || state == ST_END) ?
                   ((w == 8'h00) ? 8'h01 : w) : 8'h01;
  wire [7:0] den = (state == ST_BEGIN) ? s_beg :
                   (state == ST_END) ? s_end : 8'h01;
  wire [29:0] add = 30'(22'(fmax) * 22'(num));
  wire [29:0] thr = 30'(29'(t_act) * 29'(den));
  wire drain = (state != ST_IDLE) & (thr != 30'h0) & (acc >= thr) &
               (freq_cmd != target);
  wire zero_t = t_act == 21'h0;
  wire seg_chg = next_state != state;
  wire [29:0] acc_base = drain ? 30'(acc - thr) : acc;

  // State sequence; an S segment is skipped when its duration is zero.
  assign next_state =
    (state != ST_IDLE && (freq_cmd == target || reversed)) ? ST_IDLE :
    !tick ? state :
    (state == ST_IDLE && (want_up || want_dn)) ?
      ((s_beg == 8'h00) ? ST_LINEAR : ST_BEGIN) :
    (state == ST_BEGIN && w >= s_beg) ? ST_LINEAR :
    (state == ST_LINEAR && near) ? ST_END : state;

  // Tick counter for the 0.01 s control period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : TW'(tick_cnt + 1'b1);
    end
  end

  // Segment bookkeeping; the remainder is dropped when a segment starts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      dir <= 1'b0;
      w <= '0;
      acc <= '0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE) dir <= want_up;
      if (seg_chg) begin
        acc <= '0;
        w <= (next_state == ST_END) ? s_end : 8'h00;
      end else begin
        acc <= tick ? 30'(acc_base + add) : acc_base;
        if (tick && state == ST_BEGIN) w <= 8'(w + 1'b1);
        if (tick && state == ST_END && w != 8'h00) w <= 8'(w - 1'b1);
      end
    end
  end

  // Output frequency: one 0.01 Hz step per drained threshold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_cmd <= '0;
    end else if (zero_t) begin
      freq_cmd <= target;
    end else if (drain) begin
      freq_cmd <= dir ? 14'(freq_cmd + 1'b1) : 14'(freq_cmd - 1'b1);
    end
  end

  assign ramping = state != ST_IDLE;
  assign stat = '{state: state, dir: dir, set: ramp_set, freq: freq_cmd};

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  unit_reset_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> unit_sel == 1'b1)
    else $error("Time unit selector is not coarse after reset.");

  set_decode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg |=> ramp_set == $past({sel2, sel1}))
    else $error("Select terminals decoded to the wrong set.");

  auto_below_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cfg && auto_en && !above |=> ramp_set == SET4)
    else $error("Below switch frequency set 4 was not chosen.");

  auto_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cfg && !auto_en |=> ramp_set == SET1)
    else $error("Zero switch frequency still switched sets.");

  fine_unit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !unit_sel && !gain_on |-> t_acc == 21'(sel_acc))
    else $error("Fine unit time is not taken in 0.01 s steps.");

  coarse_unit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    unit_sel && !gain_on |-> t_acc == 21'(sel_acc) * 21'h0000a)
    else $error("Coarse unit time is not taken in 0.1 s steps.");

  zero_time_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    zero_t && freq_cmd != target |=> freq_cmd == $past(target))
    else $error("Zero ramp time did not jump to the target.");

  step_up_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    drain && dir && !zero_t |=> freq_cmd == $past(freq_cmd) + 14'h1)
    else $error("Accelerating step was not a single increment.");

  s_begin_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && state == ST_BEGIN && next_state == ST_BEGIN
    |=> w == $past(w) + 8'h01)
    else $error("S-curve start weight did not grow each tick.");

  s_end_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && state == ST_END && next_state == ST_END && w != 8'h00
    |=> w == $past(w) - 8'h01)
    else $error("S-curve end weight did not shrink each tick.");

endmodule // rts_ramp_core

//--- dv/rts_drive_model.sv
// Power stage stand-in that takes up the frequency command.
`timescale 1ns/100ps
module rts_drive_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [13:0] freq_cmd,
  output logic [13:0] applied_freq
);
  // -------------------------------------------------------------
  // Command latch
  // -------------------------------------------------------------
  // The stage follows the command one clock late and never pushes back.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_freq <= 14'h0000;
    end else begin
      applied_freq <= freq_cmd;
    end
  end
endmodule // rts_drive_model

//--- dv/ramp_time_selector_scurve_tb.sv
// Self-checking bench for the ramp time selector core.
`timescale 1ns/100ps
module ramp_time_selector_scurve_tb import rts_pkg::*;;
  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  localparam int TICK = 64;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] term_in = 2'h0;
  logic [9:0] analog_input_second = 10'h200;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [13:0] freq_cmd;
  logic [13:0] applied_freq;
  logic [1:0] ramp_set;
  logic ramping;
  int n_errors = 0;
  int check_count = 0;
  logic [15:0] lfsr = 16'h0011;
  logic [31:0] rd;
  logic er;
  logic [7:0] s [4];
  logic [15:0] t;
  logic [1:0] tv;
  logic un;
  int c;
  logic [7:0] ra [9] = '{ADDR_UNIT, ADDR_TIME0, 8'h1c, ADDR_SCRV0, 8'h3c,
    ADDR_SWF, ADDR_FMAX, ADDR_EFF_ACC, ADDR_EFF_DEC};
  logic [31:0] rv [9] = '{32'h1, 32'h64, 32'h64, 32'h14, 32'h0, 32'h0,
    32'h1770, 32'h3fc, 32'h3f2};

  // A half period of 25 ns gives the 50 ns bus clock.
  always #25 pclk = ~pclk;

  rts_ramp_core #(.TICK_CYC(TICK)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_in(term_in), .analog_input_second(analog_input_second),
    .freq_cmd(freq_cmd), .ramp_set(ramp_set), .ramping(ramping));

  rts_drive_model stage (.pclk(pclk), .presetn(presetn),
    .freq_cmd(freq_cmd), .applied_freq(applied_freq));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Effective ramp length in 0.01 s ticks, S-curve half sum included.
  function automatic logic [31:0] eff_ticks(input logic u,
    input logic [15:0] tt, input logic on, input logic [9:0] g,
    input logic [7:0] a, input logic [7:0] b);
    logic [31:0] x;
    x = u ? {16'h0, tt} * 32'd10 : {16'h0, tt};
    if (on) x = (x * {22'h0, g}) >> 9;
    return x + (({24'h0, a} + {24'h0, b}) >> 1);
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Cycle counts are bench values, so a window compare is safe here.
  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc_wait(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // Sets a target and counts cycles until the ramp settles on it.
  task automatic ramp_run(input logic [13:0] tgt, output int n);
    apb(1'b1, ADDR_TARGET, {18'h0, tgt});
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((ramping !== 1'b0 || freq_cmd !== tgt) && n < 30000);
    if (n >= 30000) n_errors++;
  endtask

  // -------------------------------------------------------------
  // Watchdog
  // -------------------------------------------------------------
  initial begin
    #(50 * 80000);
    n_errors++;
    report_and_stop();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 8'h80, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h21, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Timed ramps: fine unit, small full scale so steps stay short.
    apb(1'b1, ADDR_UNIT, 32'h0);
    apb(1'b1, ADDR_FMAX, 32'd100);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ADDR_SCRV0 + 8'(4 * k), (k > 1) ? 32'd10 : 32'd0);
    end
    apb(1'b1, ADDR_TIME0, 32'd10);
    apb(1'b1, ADDR_TIME0 + 8'h04, 32'd20);
    ramp_run(14'd100, c);
    chk_rng(c, 9 * TICK, 12 * TICK);
    cyc_wait(1);
    chk({18'h0, applied_freq}, 32'd100);
    ramp_run(14'd0, c);
    chk_rng(c, 27 * TICK, 34 * TICK);
    // Random settings against the effective time words.
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      t = {4'h0, lfsr[15:4]};
      if (i == 3) t = 16'h0;
      un = lfsr[0];
      apb(1'b1, ADDR_UNIT, {31'h0, un});
      for (int k = 0; k < 4; k++) begin
        lfsr = lfsr_next(lfsr);
        s[k] = lfsr[7:0] % 8'd251;
        apb(1'b1, ADDR_SCRV0 + 8'(4 * k), {24'h0, s[k]});
      end
      analog_input_second <= lfsr[9:0] | 10'h001;
      apb(1'b1, ADDR_AIN, (i == 1) ? 32'h5 : (i == 2) ? 32'h500 : 32'h0);
      apb(1'b1, ADDR_TIME0, {16'h0, t});
      apb(1'b1, ADDR_TIME0 + 8'h04, {16'h0, t});
      cyc_wait(6);
      apb(1'b0, ADDR_EFF_ACC, 32'h0);
      chk(rd, eff_ticks(un, t, i == 1 || i == 2,
        analog_input_second, s[0], s[1]));
      apb(1'b0, ADDR_EFF_DEC, 32'h0);
      chk(rd, eff_ticks(un, t, i == 1 || i == 2,
        analog_input_second, s[2], s[3]));
    end
    // Automatic switching with zero ramp times.
    apb(1'b1, ADDR_AIN, 32'h0);
    apb(1'b1, ADDR_UNIT, 32'h0);
    for (int k = 0; k < 12; k++) begin
      apb(1'b1, ADDR_TIME0 + 8'(4 * k), 32'h0);
    end
    ramp_run(14'd40, c);
    cyc_wait(4);
    chk({30'h0, ramp_set}, {30'h0, SET1});
    apb(1'b1, ADDR_SWF, 32'd5);
    cyc_wait(4);
    chk({30'h0, ramp_set}, {30'h0, SET4});
    ramp_run(14'd50, c);
    cyc_wait(4);
    chk({30'h0, ramp_set}, {30'h0, SET1});
    apb(1'b1, ADDR_SWF, 32'd8);
    cyc_wait(4);
    chk({30'h0, ramp_set}, {30'h0, SET4});
    apb(1'b1, ADDR_MFI, 32'h1a07);
    cyc_wait(4);
    chk({30'h0, ramp_set}, {30'h0, SET1});
    // Terminal changes while a long ramp is running.
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, ADDR_TIME0 + 8'(4 * k), 32'd200);
    end
    apb(1'b1, ADDR_TARGET, 32'd100);
    cyc_wait(TICK + 4);
    for (int i = 0; i < 10; i++) begin
      lfsr = lfsr_next(lfsr);
      tv = (i < 4) ? 2'(i) : lfsr[1:0];
      term_in <= tv;
      cyc_wait(4);
      chk({30'h0, ramp_set}, {30'h0, tv});
      chk({31'h0, ramping}, 32'h1);
    end
    report_and_stop();
  end
endmodule // ramp_time_selector_scurve_tb
